// *** rtl/pct_pkg.sv ***
package pct_pkg;
	// Register byte offsets on the APB word grid.
	localparam logic [7:0] PCT_COUNT_OFS = 8'h00;
	localparam logic [7:0] PCT_PERIOD_OFS = 8'h04;
	localparam logic [7:0] PCT_CTRL_OFS = 8'h08;
	localparam logic [7:0] PCT_MODE_OFS = 8'h0c;

	// Field positions in timer_control.
	localparam int PCT_SOFT_BIT = 11;
	localparam int PCT_FREE_BIT = 10;
	localparam int PCT_PCNT_MSB = 9;
	localparam int PCT_PCNT_LSB = 6;
	localparam int PCT_RELOAD_BIT = 5;
	localparam int PCT_STOP_BIT = 4;
	localparam int PCT_DDR_MSB = 3;
	localparam int PCT_DDR_LSB = 0;

	// Field position in timer_prescale_mode_control.
	localparam int PCT_MODE_BIT = 12;

	// Reset values.
	localparam logic [15:0] PCT_COUNT_RST = 16'hffff;
	localparam logic [15:0] PCT_PERIOD_RST = 16'hffff;
	localparam logic [15:0] PCT_PRE_RST = 16'h0000;
	localparam logic [3:0] PCT_DDR_RST = 4'h0;
	localparam logic PCT_MODE_RST = 1'b0;
	localparam logic PCT_STOP_RST = 1'b0;

	// Indirect table top entry; lower codes halve it.
	localparam logic [15:0] PCT_TABLE_TOP = 16'hffff;
	localparam logic [3:0] PCT_TABLE_LAST = 4'hf;
endpackage : pct_pkg

// *** rtl/pct_prescale_sel.sv ***
`timescale 1ns/10ps
module pct_prescale_sel (
	// Mode and selector.
	input wire logic mode_indirect,
	input wire logic [3:0] divide_down_field,
	// Value loaded into the prescaler counter.
	output logic [15:0] reload_value
);
	// Direct mode reloads the 4-bit field itself; indirect mode picks a
	// table entry of 2^(code+1)-1, so 1110 gives 7fff and 1111 gives ffff.
	always_comb begin
		if (mode_indirect) begin
			reload_value = pct_pkg::PCT_TABLE_TOP >> (pct_pkg::PCT_TABLE_LAST - divide_down_field);
		end else begin
			reload_value = {12'h000, divide_down_field};
		end
	end
endmodule : pct_prescale_sel

// *** rtl/pct_timer.sv ***
// Our own choices: the address map and register access over APB.
`timescale 1ns/10ps
module pct_timer (
	// APB clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Debugger breakpoint level from outside the clock domain.
	input wire logic debug_halt,
	// Timer events.
	output logic expiry_interrupt,
	output logic expiry_output_pin
);
	// Decodes whether an address names one of the four registers.
	function automatic logic pct_mapped(input logic [7:0] a);
		pct_mapped = (a == pct_pkg::PCT_COUNT_OFS) || (a == pct_pkg::PCT_PERIOD_OFS) ||
			(a == pct_pkg::PCT_CTRL_OFS) || (a == pct_pkg::PCT_MODE_OFS);
	endfunction : pct_mapped

	logic [15:0] count_value_reg, count_value_next;
	logic [15:0] period_value_reg, period_value_next;
	logic [15:0] pre_reg, pre_next;
	logic [3:0] divide_down_reg, divide_down_next;
	logic stop_status_reg, stop_status_next;
	logic free_run_reg, free_run_next;
	logic soft_stop_reg, soft_stop_next;
	logic prescale_mode_reg, prescale_mode_next;
	logic irq_reg, irq_next;
	logic pin_reg, pin_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic dbg_s1_reg, dbg_s2_reg, dbg_s3_reg, dbg_reg, dbg_next;
	logic [15:0] pre_reload;
	logic apb_wr;
	logic wr_count, wr_period, wr_ctrl, wr_mode;
	logic reload_strobe_bit;
	logic dbg_freeze, run, tick;
	logic [15:0] ctrl_view, mode_view, pcnt_view;

	// Prescaler reload value for the current mode and selector.
	pct_prescale_sel u_sel (
		.mode_indirect(prescale_mode_reg),
		.divide_down_field(divide_down_reg),
		.reload_value(pre_reload)
	);

	// Register views; reserved bits are tied to zero here.
	always_comb begin
		pcnt_view = prescale_mode_reg ? 16'h0000 : pre_reg;
		ctrl_view = 16'h0000;
		ctrl_view[pct_pkg::PCT_SOFT_BIT] = soft_stop_reg;
		ctrl_view[pct_pkg::PCT_FREE_BIT] = free_run_reg;
		ctrl_view[pct_pkg::PCT_PCNT_MSB:pct_pkg::PCT_PCNT_LSB] = pcnt_view[3:0];
		ctrl_view[pct_pkg::PCT_STOP_BIT] = stop_status_reg;
		ctrl_view[pct_pkg::PCT_DDR_MSB:pct_pkg::PCT_DDR_LSB] = divide_down_reg;
		mode_view = 16'h0000;
		mode_view[pct_pkg::PCT_MODE_BIT] = prescale_mode_reg;
	end

	// A write lands only at the access edge with pready high.
	assign apb_wr = psel && penable && pready_reg && pwrite;
	assign wr_count = apb_wr && (paddr == pct_pkg::PCT_COUNT_OFS);
	assign wr_period = apb_wr && (paddr == pct_pkg::PCT_PERIOD_OFS);
	assign wr_ctrl = apb_wr && (paddr == pct_pkg::PCT_CTRL_OFS);
	assign wr_mode = apb_wr && (paddr == pct_pkg::PCT_MODE_OFS);
	assign reload_strobe_bit = wr_ctrl && pwdata[pct_pkg::PCT_RELOAD_BIT];

	// APB answer: pready rises one cycle after setup, so every access has
	// exactly one access cycle; read data is captured with it.
	always_comb begin
		pready_next = psel && !penable;
		pslverr_next = 1'b0;
		prdata_next = 32'h0000_0000;
		if (psel && !penable) begin
			pslverr_next = !pct_mapped(paddr);
			if (!pwrite) begin
				unique case (paddr)
					pct_pkg::PCT_COUNT_OFS: prdata_next = {16'h0000, count_value_reg};
					pct_pkg::PCT_PERIOD_OFS: prdata_next = {16'h0000, period_value_reg};
					pct_pkg::PCT_CTRL_OFS: prdata_next = {16'h0000, ctrl_view};
					pct_pkg::PCT_MODE_OFS: prdata_next = {16'h0000, mode_view};
					default: prdata_next = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
		end
	end

	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign prdata = prdata_reg;

	// The breakpoint level is asynchronous; a change counts only once the
	// second and third stages agree, which filters a single-cycle glitch.
	always_comb begin
		dbg_next = (dbg_s2_reg == dbg_s3_reg) ? dbg_s3_reg : dbg_reg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dbg_s1_reg <= 1'b0;
			dbg_s2_reg <= 1'b0;
			dbg_s3_reg <= 1'b0;
			dbg_reg <= 1'b0;
		end else begin
			dbg_s1_reg <= debug_halt;
			dbg_s2_reg <= dbg_s1_reg;
			dbg_s3_reg <= dbg_s2_reg;
			dbg_reg <= dbg_next;
		end
	end

	// Soft stop freezes only once the counter sits at zero, before the
	// reload, so the debugger sees the exhausted state.
	assign dbg_freeze = dbg_reg && !free_run_reg &&
		(!soft_stop_reg || (count_value_reg == 16'h0000));
	assign run = !stop_status_reg && !dbg_freeze;
	assign tick = run && (pre_reg == 16'h0000);

	// Timer state. Software writes take priority over counting in the
	// same cycle, so a written value is never lost to a decrement.
	always_comb begin
		count_value_next = count_value_reg;
		period_value_next = period_value_reg;
		pre_next = pre_reg;
		divide_down_next = divide_down_reg;
		stop_status_next = stop_status_reg;
		free_run_next = free_run_reg;
		soft_stop_next = soft_stop_reg;
		prescale_mode_next = prescale_mode_reg;
		irq_next = 1'b0;
		pin_next = 1'b0;
		if (run) begin
			if (pre_reg == 16'h0000) begin
				pre_next = pre_reload;
				if (count_value_reg == 16'h0000) begin
					count_value_next = period_value_reg;
					irq_next = 1'b1;
					pin_next = 1'b1;
				end else begin
					count_value_next = count_value_reg - 16'h0001;
				end
			end else begin
				pre_next = pre_reg - 16'h0001;
			end
		end
		if (wr_count) begin
			count_value_next = pwdata[15:0];
		end
		if (wr_period) begin
			period_value_next = pwdata[15:0];
		end
		if (wr_mode) begin
			prescale_mode_next = pwdata[pct_pkg::PCT_MODE_BIT];
		end
		if (wr_ctrl) begin
			soft_stop_next = pwdata[pct_pkg::PCT_SOFT_BIT];
			free_run_next = pwdata[pct_pkg::PCT_FREE_BIT];
			stop_status_next = pwdata[pct_pkg::PCT_STOP_BIT];
			divide_down_next = pwdata[pct_pkg::PCT_DDR_MSB:pct_pkg::PCT_DDR_LSB];
			if (!prescale_mode_reg) begin
				pre_next = {12'h000, pwdata[pct_pkg::PCT_PCNT_MSB:pct_pkg::PCT_PCNT_LSB]};
			end
		end
		if (reload_strobe_bit) begin
			count_value_next = period_value_reg;
			pre_next = pre_reload;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_value_reg <= pct_pkg::PCT_COUNT_RST;
			period_value_reg <= pct_pkg::PCT_PERIOD_RST;
			pre_reg <= pct_pkg::PCT_PRE_RST;
			divide_down_reg <= pct_pkg::PCT_DDR_RST;
			stop_status_reg <= pct_pkg::PCT_STOP_RST;
			free_run_reg <= 1'b0;
			soft_stop_reg <= 1'b0;
			prescale_mode_reg <= pct_pkg::PCT_MODE_RST;
			irq_reg <= 1'b0;
			pin_reg <= 1'b0;
		end else begin
			count_value_reg <= count_value_next;
			period_value_reg <= period_value_next;
			pre_reg <= pre_next;
			divide_down_reg <= divide_down_next;
			stop_status_reg <= stop_status_next;
			free_run_reg <= free_run_next;
			soft_stop_reg <= soft_stop_next;
			prescale_mode_reg <= prescale_mode_next;
			irq_reg <= irq_next;
			pin_reg <= pin_next;
		end
	end

	assign expiry_interrupt = irq_reg;
	assign expiry_output_pin = pin_reg;

	// Checks on the timer and register behaviour.
	default clocking pct_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	reserved_read_zero_a: assert property (
		(psel && !penable && !pwrite && paddr == pct_pkg::PCT_MODE_OFS)
		|=> (prdata[31:13] == 19'h00000) && (prdata[11:0] == 12'h000))
		else $error("Reserved mode register bits read nonzero.");

	hard_halt_a: assert property (
		(dbg_reg && !free_run_reg && !soft_stop_reg && !apb_wr)
		|=> $stable(count_value_reg) && $stable(pre_reg))
		else $error("Timer moved during a hard breakpoint halt.");

	soft_halt_zero_a: assert property (
		(dbg_reg && !free_run_reg && soft_stop_reg && count_value_reg == 16'h0000 && !apb_wr)
		|=> (count_value_reg == 16'h0000) && !expiry_interrupt)
		else $error("Soft stop did not hold the counter at zero.");

	free_run_a: assert property (
		(dbg_reg && free_run_reg && !stop_status_reg && pre_reg == 16'h0000 &&
		count_value_reg != 16'h0000 && !apb_wr)
		|=> count_value_reg == $past(count_value_reg) - 16'h0001)
		else $error("Free-run counter did not decrement under breakpoint.");

	pcnt_hidden_a: assert property (
		(psel && !penable && !pwrite && paddr == pct_pkg::PCT_CTRL_OFS && prescale_mode_reg)
		|=> prdata[pct_pkg::PCT_PCNT_MSB:pct_pkg::PCT_PCNT_LSB] == 4'h0)
		else $error("Prescale count field visible in indirect mode.");

	reload_strobe_a: assert property (
		reload_strobe_bit |=> (count_value_reg == $past(period_value_reg)) &&
		(pre_reg == $past(pre_reload)))
		else $error("Reload bit did not load counter and prescaler.");

	stop_holds_a: assert property (
		(stop_status_reg && !apb_wr) |=> $stable(count_value_reg) && !expiry_interrupt)
		else $error("Timer counted while stopped.");

	direct_reload_a: assert property (
		(tick && !prescale_mode_reg && !apb_wr) |=> pre_reg == {12'h000, $past(divide_down_reg)})
		else $error("Direct prescaler reload wrong.");

	indirect_table_a: assert property (
		(tick && prescale_mode_reg && divide_down_reg == 4'he && !apb_wr) |=> pre_reg == 16'h7fff)
		else $error("Indirect prescaler table entry wrong.");

	prescale_step_a: assert property (
		(run && pre_reg != 16'h0000 && !apb_wr)
		|=> (pre_reg == $past(pre_reg) - 16'h0001) && $stable(count_value_reg))
		else $error("Prescaler did not step alone.");

	expiry_pulse_a: assert property (
		(tick && count_value_reg == 16'h0000)
		|=> expiry_interrupt && expiry_output_pin ##1 !expiry_interrupt && !expiry_output_pin)
		else $error("Expiry pulse missing or longer than one cycle.");

	period_reload_a: assert property (
		(tick && count_value_reg == 16'h0000 && !apb_wr) |=> count_value_reg == $past(period_value_reg))
		else $error("Exhausted counter not reloaded from period.");

	reload_zero_inert_a: assert property (
		(wr_ctrl && !pwdata[pct_pkg::PCT_RELOAD_BIT] && stop_status_reg &&
		pwdata[pct_pkg::PCT_STOP_BIT])
		|=> $stable(count_value_reg))
		else $error("Writing zero to the reload bit moved the counter.");

	expiry_seen_c: cover property (expiry_interrupt);
	soft_halt_seen_c: cover property (dbg_reg && soft_stop_reg && !free_run_reg && dbg_freeze);
	indirect_tick_c: cover property (tick && prescale_mode_reg);
	reload_seen_c: cover property (reload_strobe_bit);
endmodule : pct_timer

// *** dv/pct_tb.sv ***
`timescale 1ns/10ps
module tb;
	// Bench-driven design inputs and observed outputs.
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic debug_halt = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, expiry_interrupt, expiry_output_pin;
	logic [32:0] exp_q[$];
	logic [31:0] seed = 32'h00000038;
	int fails = 0;
	int check_count = 0;
	int cyc = 0, pulses = 0, last_p = 0, prev_p = 0;

	pct_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .debug_halt(debug_halt),
		.expiry_interrupt(expiry_interrupt), .expiry_output_pin(expiry_output_pin));

	// Free-running clock, 8 ns period.
	always #4 pclk = ~pclk;

	// Xorshift source, so every run repeats the same stimulus.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// Single comparison point; unknowns never match.
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; upper data bits and strobes are random because the block ignores them.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d,
		input logic [32:0] exp);
		logic [31:0] r;
		int n;
		r = rnd();
		n = 0;
		if (!wr) exp_q.push_back(exp);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {r[31:16], d};
		pstrb <= r[3:0];
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) fails++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		apb(1'b0, a, 16'h0000, {17'h0, e});
	endtask : rd

	// Read results are compared as they appear, against the oldest note.
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
			check({pslverr, prdata}, exp_q.pop_front());
		end
	end

	// Pulse log; both outputs must pulse together.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (expiry_interrupt === 1'b1 || expiry_output_pin === 1'b1) begin
			check({32'h0, expiry_output_pin}, {32'h0, expiry_interrupt});
			pulses <= pulses + 1;
			prev_p <= last_p;
			last_p <= cyc;
		end
	end

	// Waits for two fresh pulses and compares their spacing.
	task automatic gap(input int want);
		int start, n;
		start = pulses;
		n = 0;
		while (pulses < start + 2 && n < 70000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 70000) fails++;
		check(33'(last_p - prev_p), 33'(want));
	endtask : gap

	// Tells whether any pulse came within n cycles.
	task automatic window(input int n, input logic want);
		int p0;
		p0 = pulses;
		repeat (n) @(posedge pclk);
		check({32'h0, pulses != p0}, {32'h0, want});
	endtask : window

	task automatic close_out();
		$display("checks=%0d fails=%0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out

	// Main sequence.
	initial begin
		logic [31:0] v;
		logic [15:0] p, d;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(pct_pkg::PCT_PERIOD_OFS, 16'hffff);
		rd(pct_pkg::PCT_CTRL_OFS, 16'h0000);
		rd(pct_pkg::PCT_MODE_OFS, 16'h0000);
		apb(1'b0, 8'h10, 16'h0000, {1'b1, 32'h0});
		$display("test reset values done");
		wr(pct_pkg::PCT_CTRL_OFS, 16'hf010);
		rd(pct_pkg::PCT_CTRL_OFS, 16'h0010);
		v = rnd();
		wr(pct_pkg::PCT_COUNT_OFS, v[15:0]);
		rd(pct_pkg::PCT_COUNT_OFS, v[15:0]);
		v = rnd();
		wr(pct_pkg::PCT_PERIOD_OFS, v[15:0]);
		rd(pct_pkg::PCT_PERIOD_OFS, v[15:0]);
		wr(pct_pkg::PCT_MODE_OFS, 16'hffff);
		rd(pct_pkg::PCT_MODE_OFS, 16'h1000);
		wr(pct_pkg::PCT_MODE_OFS, 16'h0000);
		$display("test register access done");
		wr(pct_pkg::PCT_COUNT_OFS, 16'h0005);
		wr(pct_pkg::PCT_CTRL_OFS, 16'h0013);
		rd(pct_pkg::PCT_COUNT_OFS, 16'h0005);
		wr(pct_pkg::PCT_CTRL_OFS, 16'h0033);
		rd(pct_pkg::PCT_COUNT_OFS, v[15:0]);
		rd(pct_pkg::PCT_CTRL_OFS, 16'h00d3);
		wr(pct_pkg::PCT_CTRL_OFS, 16'h0153);
		rd(pct_pkg::PCT_CTRL_OFS, 16'h0153);
		$display("test reload done");
		p = 16'(rnd() % 4 + 1);
		d = 16'(rnd() % 3);
		// Start from zero so the first expiry comes at once, not after a random count.
		wr(pct_pkg::PCT_COUNT_OFS, 16'h0000);
		wr(pct_pkg::PCT_PERIOD_OFS, p);
		wr(pct_pkg::PCT_CTRL_OFS, d);
		gap((p + 1) * (d + 1));
		$display("test periodic done");
		wr(pct_pkg::PCT_PERIOD_OFS, 16'h0003);
		wr(pct_pkg::PCT_CTRL_OFS, 16'h0400);
		debug_halt <= 1'b1;
		window(40, 1'b1);
		wr(pct_pkg::PCT_CTRL_OFS, 16'h0000);
		repeat (8) @(posedge pclk);
		window(40, 1'b0);
		wr(pct_pkg::PCT_CTRL_OFS, 16'h0800);
		repeat (20) @(posedge pclk);
		rd(pct_pkg::PCT_COUNT_OFS, 16'h0000);
		window(40, 1'b0);
		debug_halt <= 1'b0;
		window(40, 1'b1);
		$display("test breakpoint done");
		wr(pct_pkg::PCT_CTRL_OFS, 16'h0010);
		wr(pct_pkg::PCT_PERIOD_OFS, 16'h0000);
		wr(pct_pkg::PCT_MODE_OFS, 16'h1000);
		wr(pct_pkg::PCT_CTRL_OFS, 16'h03fe);
		rd(pct_pkg::PCT_CTRL_OFS, 16'h001e);
		wr(pct_pkg::PCT_CTRL_OFS, 16'h000e);
		gap(32768);
		$display("test indirect done");
		close_out();
	end

	// Watchdog, well beyond the expected run length.
	initial begin
		repeat (90000) @(posedge pclk);
		fails++;
		close_out();
	end
endmodule : tb
